// ==== spi_status_fifo_flags.sv ====
// SPI status word, FIFO flags, register slave and serial clock divider
//
// Summary of operation
// - Excess flag set when receive count exceeds threshold
// - Excess flag clears at or below threshold
// - Receive fill count in status bits 10..8
// - Overflow flag when byte arrives at full FIFO
// - Overflow raises interrupt unless receive flush
// - Receive flag on threshold bytes, direction clear
// - Transmit flag on threshold bytes sent, direction set
// - Underflow flag when transmit starts FIFO empty
// - Underflow raises interrupt unless transmit flush
// - Transmit fill count in status bits 3..1
// - Summary flag set on any interrupt event
// - Status read clears event flags, not counts
// - Status word read-only, resets zero, 15..12 reserved
// - Receive data register pops receive FIFO
// - Divider register read/write, resets zero
// - Threshold selects one to four bytes
// - Receive flush discards bytes, no receive interrupts
// - Serial clock is clock over 2*(1+divider)
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "spi_regs.svh"

module spi_status_fifo_flags (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_start,
  input wire logic tx_done,
  output logic [7:0] tx_byte,
  output logic master_mode,
  output logic transfer_direction,
  output logic sclk_out,
  output logic irq_pending
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  spi_pkg::core_state_t s; // Registered state
  spi_pkg::core_state_t next_s; // Next state
  logic [7:0] rx_q; // Head of receive FIFO
  logic [7:0] tx_q; // Head of transmit FIFO
  logic req; // New bus request seen
  logic rd_status; // Status word read taken
  logic rd_rx; // Receive data read taken
  logic wr_tx; // Transmit data write taken
  logic wr_div; // Divider write taken
  logic wr_ctl; // Control write taken
  logic rx_flush; // Receive flush control
  logic tx_flush; // Transmit flush control
  logic dir; // Transfer direction control
  logic rx_push; // Byte enters receive FIFO
  logic rx_pop; // Byte leaves receive FIFO
  logic tx_push; // Byte enters transmit FIFO
  logic tx_pop; // Byte leaves transmit FIFO
  logic ovf_evt; // Receive overflow event
  logic rxirq_evt; // Receive threshold event
  logic txirq_evt; // Transmit threshold event
  logic uf_evt; // Transmit underflow event
  logic sum_evt; // Any interrupt event
  logic [2:0] thr; // Threshold byte count
  logic [31:0] status; // Assembled status word

  // Threshold field to byte count, 00 means one byte
  function automatic logic [2:0] thr_bytes(input logic [1:0] field);
    thr_bytes = {1'b0, field} + 3'h1;
  endfunction : thr_bytes

  // Fill count after one push and one pop
  function automatic logic [2:0] new_count(input logic [2:0] cnt, input logic push,
                                           input logic pop);
    new_count = cnt + {2'h0, push} - {2'h0, pop};
  endfunction : new_count

  // ----------------------------------------------------------------
  // Byte memories of the two FIFOs
  // ----------------------------------------------------------------
  // Read address is the next head, so the head byte is ready next cycle
  spi_byte_ram rx_ram (
    .ref_clk(ref_clk),
    .rst(rst),
    .we(rx_push),
    .waddr(s.rx_wr),
    .wdata(rx_byte),
    .raddr(next_s.rx_rd),
    .rdata(rx_q)
  );

  spi_byte_ram tx_ram (
    .ref_clk(ref_clk),
    .rst(rst),
    .we(tx_push),
    .waddr(s.tx_wr),
    .wdata(dat_i[7:0]),
    .raddr(next_s.tx_rd),
    .rdata(tx_q)
  );

  // ----------------------------------------------------------------
  // Request decode and status assembly
  // ----------------------------------------------------------------
  always_comb begin
    req = cyc_i && stb_i && (s.bus == spi_pkg::BUS_IDLE);
    rd_status = req && !we_i && (adr_i == `ADDR_STATUS);
    rd_rx = req && !we_i && (adr_i == `ADDR_RX_DATA);
    wr_tx = req && we_i && sel_i[0] && (adr_i == `ADDR_TX_DATA);
    wr_div = req && we_i && sel_i[0] && (adr_i == `ADDR_DIVIDER);
    wr_ctl = req && we_i && (adr_i == `ADDR_CONTROL);
    rx_flush = s.control[`CT_RX_FLUSH];
    tx_flush = s.control[`CT_TX_FLUSH];
    dir = s.control[`CT_DIRECTION];
    thr = thr_bytes(s.control[`CT_THR_MSB:`CT_THR_LSB]);
    // Reserved bits 15..12 and upper half read as zero
    status = `STATUS_RESET;
    status[`ST_EXCESS] = s.excess;
    status[`ST_RXCNT_MSB:`ST_RXCNT_LSB] = s.rx_cnt;
    status[`ST_OVERFLOW] = s.overflow;
    status[`ST_RXIRQ] = s.rx_irq;
    status[`ST_TXIRQ] = s.tx_irq;
    status[`ST_UNDERFLOW] = s.underflow;
    status[`ST_TXCNT_MSB:`ST_TXCNT_LSB] = s.tx_cnt;
    status[`ST_SUMMARY] = s.summary;
  end

  // ----------------------------------------------------------------
  // FIFO events and flag sources
  // ----------------------------------------------------------------
  always_comb begin
    // Flushing drops every incoming byte, so no receive event can fire
    rx_push = rx_byte_valid && !rx_flush && (s.rx_cnt != `FIFO_DEPTH);
    ovf_evt = rx_byte_valid && !rx_flush && (s.rx_cnt == `FIFO_DEPTH);
    rx_pop = rd_rx && (s.rx_cnt != `COUNT_ZERO) && !rx_flush;
    // Writes to a full transmit FIFO or during flush are dropped
    tx_push = wr_tx && !tx_flush && (s.tx_cnt != `FIFO_DEPTH);
    tx_pop = tx_start && (s.tx_cnt != `COUNT_ZERO) && !tx_flush;
    uf_evt = tx_start && (s.tx_cnt == `COUNT_ZERO);
    rxirq_evt = rx_push && !dir
                && (new_count(s.rx_cnt, rx_push, rx_pop) >= thr);
    txirq_evt = tx_done && dir && ((s.tx_sent + 3'h1) >= thr);
    // Underflow during transmit flush sets its bit but stays quiet
    sum_evt = ovf_evt || rxirq_evt || txirq_evt
              || (uf_evt && !tx_flush);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Bus slave: one wait-free answer per request, then back to idle
    case (s.bus)
      spi_pkg::BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          next_s.bus = spi_pkg::BUS_ACK;
          case (adr_i)
            `ADDR_STATUS: next_s.rdata = status;
            `ADDR_RX_DATA: next_s.rdata = {24'h000000, rx_pop ? rx_q : `BYTE_RESET};
            `ADDR_DIVIDER: next_s.rdata = {24'h000000, s.divider};
            `ADDR_CONTROL: next_s.rdata = {16'h0000, s.control};
            default: next_s.rdata = `STATUS_RESET;
          endcase
        end
      end
      spi_pkg::BUS_ACK: begin
        next_s.bus = spi_pkg::BUS_IDLE;
      end
      default: begin
        next_s.bus = spi_pkg::BUS_IDLE;
      end
    endcase

    // Register writes
    if (wr_div) begin
      next_s.divider = dat_i[7:0];
    end
    if (wr_ctl && sel_i[0]) begin
      next_s.control[7:0] = dat_i[7:0];
    end
    if (wr_ctl && sel_i[1]) begin
      next_s.control[15:8] = dat_i[15:8];
    end

    // Receive FIFO pointers and count
    if (rx_push) begin
      next_s.rx_wr = s.rx_wr + 2'h1;
    end
    if (rx_pop) begin
      next_s.rx_rd = s.rx_rd + 2'h1;
    end
    next_s.rx_cnt = new_count(s.rx_cnt, rx_push, rx_pop);
    if (rx_flush) begin
      next_s.rx_wr = `PTR_ZERO;
      next_s.rx_rd = `PTR_ZERO;
      next_s.rx_cnt = `COUNT_ZERO;
    end

    // Transmit FIFO pointers, count and outgoing byte
    if (tx_push) begin
      next_s.tx_wr = s.tx_wr + 2'h1;
    end
    if (tx_pop) begin
      next_s.tx_rd = s.tx_rd + 2'h1;
      next_s.tx_byte = tx_q;
    end else if (tx_start) begin
      // Nothing valid to send: shift out a zero byte
      next_s.tx_byte = `BYTE_RESET;
    end
    next_s.tx_cnt = new_count(s.tx_cnt, tx_push, tx_pop);
    if (tx_flush) begin
      next_s.tx_wr = `PTR_ZERO;
      next_s.tx_rd = `PTR_ZERO;
      next_s.tx_cnt = `COUNT_ZERO;
    end

    // Bytes sent since the last transmit flag, only in transmit mode
    if (!dir) begin
      next_s.tx_sent = `COUNT_ZERO;
    end else if (tx_done) begin
      next_s.tx_sent = txirq_evt ? `COUNT_ZERO : s.tx_sent + 3'h1;
    end

    // Excess follows the new count and threshold every cycle
    next_s.excess = next_s.rx_cnt
                    > thr_bytes(next_s.control[`CT_THR_MSB:`CT_THR_LSB]);

    // Sticky flags: a status read clears, a new event wins
    next_s.overflow = (s.overflow && !rd_status) || ovf_evt;
    next_s.rx_irq = (s.rx_irq && !rd_status) || rxirq_evt;
    next_s.tx_irq = (s.tx_irq && !rd_status) || txirq_evt;
    next_s.underflow = (s.underflow && !rd_status) || uf_evt;
    next_s.summary = (s.summary && !rd_status) || sum_evt;

    // Serial clock: toggles every divider+1 cycles in master mode
    if (s.control[`CT_MASTER]) begin
      if (s.sclk_cnt >= s.divider) begin
        next_s.sclk_cnt = `DIV_ZERO;
        next_s.sclk = !s.sclk;
      end else begin
        next_s.sclk_cnt = s.sclk_cnt + 8'h01;
      end
    end else begin
      // Idle low and restart from zero when master mode returns
      next_s.sclk_cnt = `DIV_ZERO;
      next_s.sclk = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ack_o = (s.bus == spi_pkg::BUS_ACK);
  assign dat_o = s.rdata;
  assign tx_byte = s.tx_byte;
  assign master_mode = s.control[`CT_MASTER];
  assign transfer_direction = s.control[`CT_DIRECTION];
  assign sclk_out = s.sclk;
  assign irq_pending = s.summary;

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  rx_count_max_a: assert property (s.rx_cnt <= `FIFO_DEPTH)
    else $error("receive count above four");

  excess_tracks_a: assert property (s.excess
      == (s.rx_cnt > thr_bytes(s.control[`CT_THR_MSB:`CT_THR_LSB])))
    else $error("excess flag does not match count");

  overflow_set_a: assert property (rx_byte_valid && !rx_flush
      && s.rx_cnt == `FIFO_DEPTH |=> s.overflow && s.summary
      && s.rx_cnt == `FIFO_DEPTH)
    else $error("overflow not flagged");

  read_clear_a: assert property (rd_status && !rx_byte_valid && !tx_start
      && !tx_done |=> !s.overflow && !s.rx_irq && !s.tx_irq && !s.underflow
      && !s.summary && s.rx_cnt == $past(s.rx_cnt))
    else $error("status read did not clear flags");

  set_wins_a: assert property (rd_status && uf_evt |=> s.underflow ##1 s.underflow
      || $past(rd_status))
    else $error("event lost against status read");

  underflow_irq_a: assert property (tx_start && s.tx_cnt == `COUNT_ZERO
      && !tx_flush |=> s.underflow && s.summary && tx_byte == `BYTE_RESET)
    else $error("underflow not flagged");

  // Under transmit flush an underflow is recorded but kept out of the
  // summary, so software polling the summary bit is not woken by it
  uf_flush_quiet_a: assert property (uf_evt && tx_flush && !s.summary && !ovf_evt
      && !rxirq_evt && !txirq_evt |=> s.underflow && !s.summary)
    else $error("flushed underflow raised the summary");

  rx_flush_quiet_a: assert property (rx_flush |=> s.rx_cnt == `COUNT_ZERO
      && !$rose(s.rx_irq) && !$rose(s.overflow))
    else $error("receive flush let data or flags through");

  rx_irq_a: assert property (rxirq_evt |=> s.rx_irq && s.summary
      && s.rx_cnt >= $past(thr))
    else $error("receive flag missed");

  sclk_step_a: assert property (master_mode && $stable(s.divider)
      && s.sclk_cnt == s.divider && !wr_ctl |=> $changed(sclk_out)
      ##1 (s.divider == `DIV_ZERO) || $stable(sclk_out))
    else $error("serial clock period wrong");

  ack_pulse_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle");

  overflow_c: cover property (ovf_evt ##1 rd_status);
  tx_irq_c: cover property (txirq_evt);
  underflow_flush_c: cover property (uf_evt && tx_flush);
  excess_c: cover property ($rose(s.excess));
  // Event and clearing read on the same edge
  coincide_c: cover property (rd_status && uf_evt);

endmodule : spi_status_fifo_flags

// ==== spi_regs.svh ====
// Register map, field positions and reset values of the SPI status block
`ifndef SPI_REGS_SVH
`define SPI_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_STATUS 32'hFFFF0A00
`define ADDR_RX_DATA 32'hFFFF0A04
`define ADDR_TX_DATA 32'hFFFF0A08
`define ADDR_DIVIDER 32'hFFFF0A0C
`define ADDR_CONTROL 32'hFFFF0A10

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define STATUS_RESET 32'h00000000
`define BYTE_RESET 8'h00
`define CONTROL_RESET 16'h0000
`define FIFO_DEPTH 3'h4
`define COUNT_ZERO 3'h0
`define PTR_ZERO 2'h0
`define DIV_ZERO 8'h00

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define ST_EXCESS 11
`define ST_RXCNT_MSB 10
`define ST_RXCNT_LSB 8
`define ST_OVERFLOW 7
`define ST_RXIRQ 6
`define ST_TXIRQ 5
`define ST_UNDERFLOW 4
`define ST_TXCNT_MSB 3
`define ST_TXCNT_LSB 1
`define ST_SUMMARY 0

// ----------------------------------------------------------------
// Control word bit positions
// ----------------------------------------------------------------
`define CT_MASTER 0
`define CT_DIRECTION 1
`define CT_TX_FLUSH 2
`define CT_RX_FLUSH 3
`define CT_THR_LSB 4
`define CT_THR_MSB 5

`endif

// ==== spi_pkg.sv ====
// Types shared by the SPI status block and its byte memory
package spi_pkg;

  // ----------------------------------------------------------------
  // Bus answer states, one bit changes per step
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_t;

  // Four-byte memory with registered read data
  typedef struct packed {
    logic [3:0][7:0] mem;
    logic [7:0] rdata;
  } ram_state_t;

  // Whole state of the status block
  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic [1:0] rx_wr;
    logic [1:0] rx_rd;
    logic [2:0] rx_cnt;
    logic [1:0] tx_wr;
    logic [1:0] tx_rd;
    logic [2:0] tx_cnt;
    logic excess;
    logic overflow;
    logic rx_irq;
    logic tx_irq;
    logic underflow;
    logic summary;
    logic [7:0] divider;
    logic [15:0] control;
    logic [7:0] tx_byte;
    logic [2:0] tx_sent;
    logic [7:0] sclk_cnt;
    logic sclk;
  } core_state_t;

endpackage : spi_pkg

// ==== spi_byte_ram.sv ====
// Four-byte memory with one write port and a registered read port
`timescale 1ns/10ps

module spi_byte_ram (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] raddr,
  output logic [7:0] rdata
);

  spi_pkg::ram_state_t s; // Stored bytes and read register
  spi_pkg::ram_state_t next_s; // Next value of the state

  // ----------------------------------------------------------------
  // Write, then read with bypass
  // ----------------------------------------------------------------
  // Bypass keeps a byte written at this edge visible at once
  always_comb begin
    next_s = s;
    if (we) begin
      next_s.mem[waddr] = wdata;
    end
    next_s.rdata = next_s.mem[raddr];
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;

endmodule : spi_byte_ram

// ==== spi_far_side.sv ====
// Behavioural model of the serial shifter that feeds the status block
`timescale 1ns/10ps

module spi_far_side (
  input wire logic ref_clk,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic tx_start,
  output logic tx_done
);
  // ----------------------------------------------------------------
  // Idle levels at time zero
  // ----------------------------------------------------------------
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'hA5;
    tx_start = 1'b0;
    tx_done = 1'b0;
  end

  // Deliver one received byte as a one-cycle pulse
  task automatic give_rx(input logic [7:0] b);
    @(posedge ref_clk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge ref_clk);
    rx_byte_valid <= 1'b0;
    // Released data shows the inverse so stale data never looks valid
    rx_byte <= ~b;
  endtask : give_rx

  // One-cycle pulse on start (0) or done (1)
  task automatic pulse(input logic which);
    @(posedge ref_clk);
    if (which) begin
      tx_done <= 1'b1;
    end else begin
      tx_start <= 1'b1;
    end
    @(posedge ref_clk);
    tx_done <= 1'b0;
    tx_start <= 1'b0;
  endtask : pulse
endmodule : spi_far_side

// ==== tb.sv ====
// Self-checking testbench of the SPI status and FIFO flag block
`timescale 1ns/10ps
`include "spi_regs.svh"

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] adr; // Bus request fields, given idle values at time zero
  logic [31:0] wdat;
  logic [31:0] dat_o;
  logic [3:0] sel;
  logic we;
  logic cyc;
  logic stb;
  logic ack_o;
  logic rx_byte_valid, tx_start, tx_done;
  logic [7:0] rx_byte, tx_byte;
  logic master_mode, transfer_direction, sclk_out, irq_pending;
  int err_count = 0;
  int n_compared = 0;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  spi_status_fifo_flags dut (.ref_clk(ref_clk), .rst(rst), .adr_i(adr), .dat_i(wdat),
    .dat_o(dat_o), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_start(tx_start),
    .tx_done(tx_done), .tx_byte(tx_byte), .master_mode(master_mode),
    .transfer_direction(transfer_direction), .sclk_out(sclk_out),
    .irq_pending(irq_pending));

  spi_far_side u_far (.ref_clk(ref_clk), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .tx_start(tx_start), .tx_done(tx_done));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  // Classic single Wishbone cycle; the wait is bounded
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      err_count++;
      wrap_up();
    end
  endtask : wb

  // Let the updates of the last edge land before looking
  task automatic settle;
    @(negedge ref_clk);
  endtask : settle

  // Expected status word from its fields
  function automatic logic [31:0] st(input logic ex, input logic [2:0] rc,
                                     input logic [3:0] fl, input logic [2:0] tc,
                                     input logic sm);
    return {20'h00000, ex, rc, fl, tc, sm};
  endfunction : st

  // Edges from one serial clock rise to the next, bounded
  task automatic next_rise(output int c);
    logic p;
    c = 0;
    do begin
      p = sclk_out;
      @(posedge ref_clk);
      c++;
    end while (!(p === 1'b0 && sclk_out === 1'b1) && c < 100);
    if (c >= 100) begin
      err_count++;
      wrap_up();
    end
  endtask : next_rise

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    wb(0, `ADDR_STATUS, 32'h0, q); chk("status_rst", 32'h0, q);
    wb(0, `ADDR_RX_DATA, 32'h0, q); chk("rx_rst", 32'h0, q);
    wb(0, `ADDR_DIVIDER, 32'h0, q); chk("div_rst", 32'h0, q);
    wb(0, `ADDR_CONTROL + 32'h4, 32'h0, q); chk("unmapped", 32'h0, q);
    wb(1, `ADDR_STATUS, 32'hFFFFFFFF, q);
    wb(0, `ADDR_STATUS, 32'h0, q); chk("status_ro", 32'h0, q);
  endtask : t_reset

  task automatic t_clock;
    logic [31:0] q;
    int c;
    wb(1, `ADDR_DIVIDER, 32'h2, q);
    wb(0, `ADDR_DIVIDER, 32'h0, q); chk("div_rw", 32'h2, q);
    // A write with no byte enabled must leave the divider alone
    sel <= 4'h0;
    wb(1, `ADDR_DIVIDER, 32'h7F, q);
    sel <= 4'hF;
    wb(0, `ADDR_DIVIDER, 32'h0, q); chk("div_sel", 32'h2, q);
    wb(1, `ADDR_CONTROL, 32'h1, q);
    chk("master", 32'h1, 32'(master_mode));
    wb(0, `ADDR_CONTROL, 32'h0, q); chk("ctl_rw", 32'h1, q);
    next_rise(c);
    next_rise(c); chk("sclk_period", 32'd6, 32'(c));
  endtask : t_clock

  // Every threshold code, fill counts, excess, overflow and pops
  task automatic t_rx;
    logic [31:0] q;
    for (int t = 0; t < 4; t++) begin
      wb(1, `ADDR_CONTROL, 32'h8 | 32'(t << 4), q);
      wb(1, `ADDR_CONTROL, 32'(t << 4), q);
      wb(0, `ADDR_STATUS, 32'h0, q);
      for (int n = 0; n < t; n++) u_far.give_rx(8'(8'h10 + n));
      settle(); chk("irq_below", 32'h0, 32'(irq_pending));
      u_far.give_rx(8'(8'h10 + t));
      settle(); chk("irq_at", 32'h1, 32'(irq_pending));
      if (t < 3) u_far.give_rx(8'h55);
      wb(0, `ADDR_STATUS, 32'h0, q);
      chk("rx_status", st(t < 3, 3'(t < 3 ? t + 2 : 4), 4'h4, 3'h0, 1'b1), q);
    end
    u_far.give_rx(8'h99);
    wb(0, `ADDR_STATUS, 32'h0, q);
    chk("overflow", st(0, 3'h4, 4'h8, 3'h0, 1'b1), q);
    wb(0, `ADDR_STATUS, 32'h0, q);
    chk("read_clear", st(0, 3'h4, 4'h0, 3'h0, 1'b0), q);
    for (int n = 0; n < 4; n++) begin
      wb(0, `ADDR_RX_DATA, 32'h0, q); chk("rx_data", 32'(8'h10 + n), q);
    end
    wb(0, `ADDR_STATUS, 32'h0, q); chk("rx_empty", 32'h0, q);
    wb(1, `ADDR_CONTROL, 32'h8, q);
    u_far.give_rx(8'h66);
    wb(0, `ADDR_STATUS, 32'h0, q); chk("rx_flush", 32'h0, q);
  endtask : t_rx

  task automatic t_tx;
    logic [31:0] q;
    wb(1, `ADDR_CONTROL, 32'h2, q);
    chk("direction", 32'h1, 32'(transfer_direction));
    wb(0, `ADDR_STATUS, 32'h0, q);
    wb(1, `ADDR_TX_DATA, 32'h5A, q);
    wb(1, `ADDR_TX_DATA, 32'hC3, q);
    wb(1, `ADDR_TX_DATA, 32'h11, q);
    wb(1, `ADDR_TX_DATA, 32'h22, q);
    wb(0, `ADDR_STATUS, 32'h0, q); chk("tx_full", st(0, 3'h0, 4'h0, 3'h4, 1'b0), q);
    u_far.pulse(1'b0);
    settle(); chk("tx_byte", 32'h5A, 32'(tx_byte));
    u_far.pulse(1'b1);
    wb(0, `ADDR_STATUS, 32'h0, q); chk("tx_irq", st(0, 3'h0, 4'h2, 3'h3, 1'b1), q);
    wb(1, `ADDR_CONTROL, 32'h6, q);
    wb(1, `ADDR_CONTROL, 32'h2, q);
    u_far.pulse(1'b0);
    wb(0, `ADDR_STATUS, 32'h0, q); chk("underflow", st(0, 3'h0, 4'h1, 3'h0, 1'b1), q);
    chk("tx_byte_uf", 32'h0, 32'(tx_byte));
    wb(1, `ADDR_CONTROL, 32'h6, q);
    wb(1, `ADDR_TX_DATA, 32'h44, q);
    u_far.pulse(1'b0);
    wb(0, `ADDR_STATUS, 32'h0, q); chk("uf_flush", st(0, 3'h0, 4'h1, 3'h0, 1'b0), q);
  endtask : t_tx

  // Event lands on the same edge as the clearing status read
  task automatic t_coincide;
    logic [31:0] q;
    wb(1, `ADDR_CONTROL, 32'h0, q);
    wb(0, `ADDR_STATUS, 32'h0, q);
    fork
      wb(0, `ADDR_STATUS, 32'h0, q);
      u_far.give_rx(8'h77);
      u_far.pulse(1'b0);
    join
    wb(0, `ADDR_STATUS, 32'h0, q); chk("set_wins", st(0, 3'h1, 4'h5, 3'h0, 1'b1), q);
  endtask : t_coincide

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // Bus idle, all bytes enabled
    adr <= 32'h0;
    wdat <= 32'h0;
    sel <= 4'hF;
    we <= 1'b0;
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_clock();
    t_rx();
    t_tx();
    t_coincide();
    wrap_up();
  end
endmodule : tb
